/* shared/msgbuf_defs.vh */
`ifndef MSGBUF_DEFS_VH
`define MSGBUF_DEFS_VH
// buffer geometry
`define NUM_BUF        4
`define BUF_IDX_W      2
`define DATA_WORDS     16
`define DATA_BYTES     32
`define MEM_DEPTH      64
// per-buffer word slots inside the buffer memory
`define SLOT_HDR       4'h0
`define SLOT_LEN       4'h1
`define SLOT_CRC       4'h2
`define SLOT_DATA0     4'h3
// apb register map (byte addresses)
`define REG_CTRL       12'h000
`define REG_SPL        12'h004
`define REG_MPL        12'h008
`define REG_ERR        12'h00C
`define REG_ALIGN      12'h010
`define REG_CYCLE      12'h014
`define REG_BUFCFG0    12'h020
`define REG_STATUS0    12'h040
`define REG_BUFMEM     12'h400
// header word fields of a buffer
`define HDR_RSV        15
`define HDR_PP         14
`define HDR_NFI        13
`define HDR_SYNC       12
`define HDR_SUP        11
// slot status fields
`define ST_CH          8
`define ST_VCE         7
`define ST_ALIGNMENT_FRAME_SEEN_FLAG       6
`define ST_EMPTY_FRAME_SEEN_FLAG       5
`define ST_STARTUP_FRAME_SEEN_FLAG        4
`define ST_SYNTAX_FAULT_FLAG        3
`define ST_CONTENT_FAULT_FLAG        2
`define ST_SLOT_BOUNDARY_ACTIVITY_FLAG       1
`define ST_TRANSMIT_CONFLICT_FLAG       0
// buffer config fields
`define CFG_TX         15
`define CFG_DYN        14
`define CFG_CHB        13
`define CFG_CHA        12
// error register bits
`define ERR_STATIC_LENGTH_MISMATCH_ERR      0
`define ERR_DYNAMIC_LENGTH_EXCESS_ERR      1
// reset values
`define STATUS_RST     16'h0000
`define STATUS_EMPTY_B 16'h0100
`define SPL_RST        7'h10
`define MPL_RST        7'h10
`endif

/* rtl/buf_mem.v */
`timescale 1ns/1ps
module buf_mem (
	input  wire        pclk,
	input  wire        we_a,
	input  wire [5:0]  addr_a,
	input  wire [15:0] wdata_a,
	input  wire [5:0]  addr_b,
	output reg  [15:0] rdata_b,
	input  wire [5:0]  addr_c,
	output reg  [15:0] rdata_c
);
	reg [15:0] mem [0:63];
	always @(posedge pclk) begin
		if (we_a) begin
			mem[addr_a] <= wdata_a;
		end
		rdata_b <= mem[addr_b];
		rdata_c <= mem[addr_c];
	end
endmodule

/* rtl/msg_buffer_core.v */
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "msgbuf_defs.vh"
// How it works
// RULE_01: rx frame goes to first matching buffer
// RULE_02: tx only in slot equal frame id
// RULE_03: fifo stores id only if filters pass
// RULE_04: reserved header bit sent unchanged
// RULE_05: preamble bit marks nm vector or message id
// RULE_06: null indicator cleared at reset, sticky set
// RULE_07: null frames never written into buffers
// RULE_08: store own cycle counter on reception
// RULE_09: length counts sixteen-bit payload words
// RULE_10: static length mismatch raises host error
// RULE_11: dynamic length excess raises host error
// RULE_12: payload limited to thirty-two bytes
// RULE_13: header crc stored, sent unchecked
// RULE_14: sync/startup bits rewritten on valid store
// RULE_15: sync slot and startup from config register
// RULE_16: nine-bit status, tx only conflict bit
// RULE_17: invalid/null updates status only
// RULE_18: update completes in first macrotick next slot
// RULE_19: empty static slot reads 0000 or 0100
// RULE_20: conflict set if rx busy at tx start
// RULE_21: content, syntax, boundary flags from receiver
// RULE_22: startup, null, sync flags from header
// RULE_23: valid element flag on correct frame
// RULE_24: channel bit zero A, one B
// RULE_25: fifo payload only if filters pass
// RULE_26: all flags written in one update
module msg_buffer_core (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        slot_end,
	input  wire        macrotick,
	input  wire [10:0] slot_number,
	input  wire        slot_dynamic,
	input  wire        rx_done,
	input  wire        rx_channel,
	input  wire [10:0] rx_frame_id,
	input  wire [15:0] rx_header,
	input  wire [6:0]  rx_length,
	input  wire [10:0] rx_crc,
	input  wire        rx_syntax_ok,
	input  wire        rx_content_ok,
	input  wire        rx_boundary,
	input  wire        rx_data_valid,
	input  wire [3:0]  rx_data_index,
	input  wire [15:0] rx_data,
	input  wire        rx_busy,
	input  wire        fifo_accept,
	input  wire        fifo_reject,
	output reg         tx_start,
	output reg  [15:0] tx_header,
	output reg  [6:0]  tx_length,
	output reg  [10:0] tx_crc,
	output reg         tx_channel_a,
	output reg         tx_channel_b,
	input  wire [3:0]  tx_data_index,
	output wire [15:0] tx_data,
	output reg         fifo_write,
	output reg  [10:0] fifo_frame_id,
	output reg         status_update_done
);
	localparam S_IDLE = 3'b000;
	localparam S_UPD  = 3'b001;
	localparam S_DONE = 3'b010;
	localparam S_LEN  = 3'b011;
	localparam S_CRC  = 3'b100;

	reg                   enable;
	reg  [6:0]            static_payload_length_cfg;
	reg  [6:0]            max_dynamic_payload_cfg;
	reg  [1:0]            host_interface_error_reg;
	reg  [10:0]           alignment_slot;
	reg                   tx_startup_flag_cfg;
	reg  [5:0]            cycle_counter;
	reg  [15:0]           buf_cfg [0:`NUM_BUF-1];
	reg  [10:0]           buf_filter [0:`NUM_BUF-1];
	reg  [5:0]            buf_cycle_mask [0:`NUM_BUF-1];
	reg  [15:0]           buffer_slot_status [0:`NUM_BUF-1];
	reg  [`NUM_BUF-1:0]   null_frame_indicator;
	reg  [2:0]            state;
	reg                   tx_sent;
	reg                   mem_wait;
	reg  [`BUF_IDX_W-1:0] sel_buf;
	reg                   sel_hit;
	reg  [15:0]           next_status;
	reg  [`BUF_IDX_W-1:0] tx_buf;
	reg                   tx_hit;
	integer               i;

	wire        bus_wr = psel && penable && pwrite;
	wire        bus_rd = psel && !penable && !pwrite;
	wire        mem_hit = paddr[11:10] == 2'b01;
	wire [1:0]  mem_buf = paddr[7:6];
	wire [3:0]  mem_slot = paddr[5:2];
	wire [5:0]  mem_addr = {mem_buf, mem_slot};
	wire        rx_valid = rx_syntax_ok && rx_content_ok;
	wire        rx_null  = !rx_header[`HDR_NFI];
	reg         cpu_we;
	reg  [5:0]  cpu_addr;
	reg  [15:0] cpu_wdata;
	wire [15:0] mem_rdata;
	wire [15:0] cpu_len = pwdata[15:0];
	wire        rx_store = rx_done && sel_hit && rx_valid && !rx_null;
	// one transmission per slot, never on the slot-end edge
	wire        tx_fire = enable && macrotick && !slot_end && state == S_IDLE &&
	                      tx_hit && !tx_start && !tx_sent;

	// buffer memory reads take one wait state for the registered memory output
	assign pready  = !(psel && penable && !pwrite && mem_hit && !mem_wait);
	assign pslverr = 1'b0;

	// first receive buffer whose filter, channel and cycle match
	always @* begin
		sel_buf = {`BUF_IDX_W{1'b0}};
		sel_hit = 1'b0;
		for (i = `NUM_BUF - 1; i >= 0; i = i - 1) begin
			if (!buf_cfg[i][`CFG_TX] && buf_filter[i] == rx_frame_id && //RULE_01
			    (rx_channel ? buf_cfg[i][`CFG_CHB] : buf_cfg[i][`CFG_CHA]) &&
			    ((cycle_counter & buf_cycle_mask[i]) == 6'h00)) begin
				sel_buf = i[`BUF_IDX_W-1:0];
				sel_hit = 1'b1;
			end
		end
	end

	// transmit buffer for this slot
	always @* begin
		tx_buf = {`BUF_IDX_W{1'b0}};
		tx_hit = 1'b0;
		for (i = `NUM_BUF - 1; i >= 0; i = i - 1) begin
			if (buf_cfg[i][`CFG_TX] && buf_filter[i] == slot_number && //RULE_02
			    (buf_cfg[i][`CFG_CHA] || buf_cfg[i][`CFG_CHB]) &&
			    ((cycle_counter & buf_cycle_mask[i]) == 6'h00)) begin
				tx_buf = i[`BUF_IDX_W-1:0];
				tx_hit = 1'b1;
			end
		end
	end

	// all receive flags assembled into one word
	always @* begin
		next_status = `STATUS_RST;
		next_status[`ST_CH]    = rx_channel; //RULE_24
		next_status[`ST_VCE]   = rx_valid; //RULE_23
		next_status[`ST_ALIGNMENT_FRAME_SEEN_FLAG] = rx_syntax_ok && rx_header[`HDR_SYNC]; //RULE_22
		next_status[`ST_EMPTY_FRAME_SEEN_FLAG] = rx_syntax_ok && rx_null;
		next_status[`ST_STARTUP_FRAME_SEEN_FLAG]  = rx_syntax_ok && rx_header[`HDR_SUP];
		next_status[`ST_SYNTAX_FAULT_FLAG]  = !rx_syntax_ok; //RULE_21
		next_status[`ST_CONTENT_FAULT_FLAG]  = rx_syntax_ok && !rx_content_ok;
		next_status[`ST_SLOT_BOUNDARY_ACTIVITY_FLAG] = rx_boundary;
	end

	// memory writes: host first, then received payload, header, length and crc
	always @* begin
		cpu_we    = 1'b0;
		cpu_addr  = mem_addr;
		cpu_wdata = pwdata[15:0];
		if (bus_wr && mem_hit) begin
			cpu_we = 1'b1;
		end else if (enable && rx_data_valid && rx_valid && !rx_null && //RULE_07
		             sel_hit) begin
			cpu_we    = 1'b1;
			cpu_addr  = {sel_buf, `SLOT_DATA0 + rx_data_index}; //RULE_12
			cpu_wdata = rx_data;
		end else if (state == S_UPD && rx_store) begin //RULE_17
			cpu_we    = 1'b1;
			cpu_addr  = {sel_buf, `SLOT_HDR};
			cpu_wdata = {rx_header[15:11], rx_frame_id}; //RULE_14
		end else if (state == S_LEN && rx_store) begin
			cpu_we    = 1'b1;
			cpu_addr  = {sel_buf, `SLOT_LEN};
			cpu_wdata = {2'b00, cycle_counter, 1'b0, rx_length}; //RULE_08
		end else if (state == S_CRC && rx_store) begin
			cpu_we    = 1'b1;
			cpu_addr  = {sel_buf, `SLOT_CRC};
			cpu_wdata = {5'h00, rx_crc}; //RULE_13
		end
	end

	buf_mem u_mem (
		.pclk    (pclk),
		.we_a    (cpu_we),
		.addr_a  (cpu_addr),
		.wdata_a (cpu_wdata),
		.addr_b  (mem_addr),
		.rdata_b (mem_rdata),
		.addr_c  ({tx_buf, `SLOT_DATA0 + tx_data_index}),
		.rdata_c (tx_data)
	);

	// host registers and error flags
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable                    <= 1'b0;
			static_payload_length_cfg <= `SPL_RST;
			max_dynamic_payload_cfg   <= `MPL_RST;
			host_interface_error_reg  <= 2'b00;
			alignment_slot            <= 11'h000;
			tx_startup_flag_cfg       <= 1'b0;
			for (i = 0; i < `NUM_BUF; i = i + 1) begin
				buf_cfg[i]        <= 16'h0000;
				buf_filter[i]     <= 11'h000;
				buf_cycle_mask[i] <= 6'h00;
			end
		end else if (bus_wr) begin
			case (paddr)
				`REG_CTRL:  enable <= pwdata[0];
				`REG_SPL:   static_payload_length_cfg <= pwdata[6:0];
				`REG_MPL:   max_dynamic_payload_cfg <= pwdata[6:0];
				`REG_ERR:   host_interface_error_reg <= host_interface_error_reg & ~pwdata[1:0];
				`REG_ALIGN: begin
					alignment_slot      <= pwdata[10:0]; //RULE_15
					tx_startup_flag_cfg <= pwdata[16];
				end
				default: begin
					if (paddr[11:5] == 7'h01) begin
						buf_cfg[paddr[3:2]] <= pwdata[15:0];
						buf_cycle_mask[paddr[3:2]] <= pwdata[21:16];
						buf_filter[paddr[3:2]] <= pwdata[10:0];
					end
				end
			endcase
			// length check when the host writes a transmit length word
			if (mem_hit && mem_slot == `SLOT_LEN && buf_cfg[mem_buf][`CFG_TX]) begin //RULE_09
				if (!buf_cfg[mem_buf][`CFG_DYN] &&
				    cpu_len[6:0] != static_payload_length_cfg) begin
					host_interface_error_reg[`ERR_STATIC_LENGTH_MISMATCH_ERR] <= 1'b1; //RULE_10
				end
				if (buf_cfg[mem_buf][`CFG_DYN] &&
				    cpu_len[6:0] > max_dynamic_payload_cfg) begin
					host_interface_error_reg[`ERR_DYNAMIC_LENGTH_EXCESS_ERR] <= 1'b1; //RULE_11
				end
			end
		end
	end

	// slot-end update sequence, finished on next slot's first macrotick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                <= S_IDLE;
			status_update_done   <= 1'b0;
			null_frame_indicator <= {`NUM_BUF{1'b0}}; //RULE_06
			cycle_counter        <= 6'h00;
			fifo_write           <= 1'b0;
			fifo_frame_id        <= 11'h000;
			for (i = 0; i < `NUM_BUF; i = i + 1) begin
				buffer_slot_status[i] <= `STATUS_RST;
			end
		end else begin
			status_update_done <= 1'b0;
			fifo_write         <= 1'b0;
			case (state)
				S_IDLE: begin
					if (enable && slot_end) begin
						state <= S_UPD;
					end
				end
				S_UPD: begin
					if (rx_done && sel_hit) begin
						buffer_slot_status[sel_buf] <= next_status; //RULE_26
						if (rx_valid && !rx_null) begin
							null_frame_indicator[sel_buf] <= 1'b1;
						end
					end else if (!rx_done && !slot_dynamic) begin
						for (i = 0; i < `NUM_BUF; i = i + 1) begin
							if (!buf_cfg[i][`CFG_TX] && buf_filter[i] == slot_number) begin
								buffer_slot_status[i] <= buf_cfg[i][`CFG_CHB] ?
									`STATUS_EMPTY_B : `STATUS_RST; //RULE_19
							end
						end
					end
					if (rx_done && !sel_hit && rx_valid && !rx_null &&
					    fifo_accept && !fifo_reject) begin
						fifo_write    <= 1'b1; //RULE_03 RULE_25
						fifo_frame_id <= rx_frame_id;
					end
					state <= S_LEN;
				end
				S_LEN: begin
					state <= S_CRC;
				end
				S_CRC: begin
					state <= S_DONE;
				end
				S_DONE: begin
					if (macrotick) begin //RULE_18
						status_update_done <= 1'b1;
						if (slot_number == 11'h001) begin
							cycle_counter <= cycle_counter + 6'h01;
						end
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
			if (tx_start && tx_hit) begin
				buffer_slot_status[tx_buf][`ST_TRANSMIT_CONFLICT_FLAG] <= rx_busy; //RULE_20
			end
		end
	end

	// transmit path: header sent with sync/startup bits from the alignment config and null indicator set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_start     <= 1'b0;
			tx_header    <= 16'h0000;
			tx_length    <= 7'h00;
			tx_crc       <= 11'h000;
			tx_channel_a <= 1'b0;
			tx_channel_b <= 1'b0;
			tx_sent      <= 1'b0;
		end else begin
			tx_start <= tx_fire;
			tx_sent  <= !slot_end && (tx_sent || tx_fire);
			if (tx_hit) begin
				tx_channel_a <= buf_cfg[tx_buf][`CFG_CHA];
				tx_channel_b <= buf_cfg[tx_buf][`CFG_CHB];
				tx_header[`HDR_SYNC] <= slot_number == alignment_slot;
				tx_header[`HDR_SUP]  <= tx_startup_flag_cfg && slot_number == alignment_slot;
			end
			if (bus_wr && mem_hit && mem_buf == tx_buf) begin
				if (mem_slot == `SLOT_HDR) begin
					tx_header[`HDR_RSV] <= pwdata[`HDR_RSV]; //RULE_04
					tx_header[`HDR_PP]  <= pwdata[`HDR_PP]; //RULE_05
					tx_header[`HDR_NFI] <= 1'b1;
					tx_header[10:0]     <= pwdata[10:0];
				end
				if (mem_slot == `SLOT_LEN) begin
					tx_length <= (pwdata[6:0] > 7'h10) ? 7'h10 : pwdata[6:0];
				end
				if (mem_slot == `SLOT_CRC) begin
					tx_crc <= pwdata[10:0]; //RULE_13
				end
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wait <= 1'b0;
		end else begin
			mem_wait <= psel && penable && !pwrite && mem_hit && !mem_wait;
		end
	end

	// apb read data: registers latched in setup phase, buffer memory in access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (bus_rd) begin
			prdata <= 32'h00000000;
			case (paddr)
				`REG_CTRL:  prdata <= {31'h0, enable};
				`REG_SPL:   prdata <= {25'h0, static_payload_length_cfg};
				`REG_MPL:   prdata <= {25'h0, max_dynamic_payload_cfg};
				`REG_ERR:   prdata <= {30'h0, host_interface_error_reg};
				`REG_ALIGN: prdata <= {15'h0, tx_startup_flag_cfg, 5'h0, alignment_slot};
				`REG_CYCLE: prdata <= {26'h0, cycle_counter}; //RULE_08
				default: begin
					if (paddr[11:5] == 7'h02) begin
						prdata <= {12'h0, null_frame_indicator[paddr[3:2]],
							3'h0, buffer_slot_status[paddr[3:2]]}; //RULE_16
					end
				end
			endcase
		end else if (psel && penable && !pwrite && mem_hit) begin
			prdata <= {16'h0000, mem_rdata};
		end
	end
endmodule

/* dv/msg_buffer_checker_assertions.sv */
`timescale 1ns/1ps
module msg_buffer_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	input wire        slot_end,
	input wire        rx_done,
	input wire [15:0] rx_header,
	input wire        rx_syntax_ok,
	input wire        rx_content_ok,
	input wire        fifo_accept,
	input wire        fifo_reject,
	input wire        fifo_write,
	input wire        tx_start,
	input wire [6:0]  tx_length,
	input wire        tx_channel_a,
	input wire        tx_channel_b,
	input wire        status_update_done
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_apb_no_error: assert property (!pslverr)
		else $error("apb slave flagged an error");
	a_apb_wait_once: assert property (psel && penable && !pready |=> pready)
		else $error("apb slave held more than one wait state");
	a_fifo_filter_pass: assert property (fifo_write |-> $past(fifo_accept) && !$past(fifo_reject))
		else $error("fifo element written against the filters");
	a_fifo_after_rx: assert property (fifo_write |-> $past(rx_done))
		else $error("fifo element written with no frame received");
	a_null_not_stored: assert property (fifo_write |-> $past(rx_header[13]))
		else $error("null frame stored into fifo");
	a_invalid_not_stored: assert property (fifo_write |-> $past(rx_syntax_ok && rx_content_ok))
		else $error("invalid frame stored into fifo");
	a_update_in_time: assert property (slot_end |-> ##[1:12] status_update_done)
		else $error("buffer update not finished in next slot");
	a_update_single: assert property (status_update_done |=> !status_update_done)
		else $error("status update split over cycles");
	a_tx_on_channel: assert property (tx_start |-> (tx_channel_a || tx_channel_b))
		else $error("transmit started on no channel");
	a_tx_len_clamp: assert property (tx_start |-> tx_length <= 7'h10)
		else $error("transmit length beyond payload area");
	c_tx: cover property (tx_start);
	c_fifo: cover property (fifo_write);
	c_upd: cover property (slot_end ##[1:12] status_update_done);
endmodule
bind msg_buffer_core msg_buffer_checker chk_u (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .slot_end,
	.rx_done, .rx_header, .rx_syntax_ok, .rx_content_ok, .fifo_accept, .fifo_reject,
	.fifo_write, .tx_start, .tx_length, .tx_channel_a, .tx_channel_b, .status_update_done);

/* dv/apb_host_model.sv */
`timescale 1ns/1ps
module apb_host_model (
	input  wire        pclk,
	output reg         psel,
	output reg         penable,
	output reg         pwrite,
	output reg  [11:0] paddr,
	output reg  [31:0] pwdata,
	input  wire [31:0] prdata,
	input  wire        pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			r = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			// released bus must not keep showing the last values
			paddr <= ~a;
			pwdata <= ~d;
		end
	endtask
endmodule

/* dv/msg_buffer_fields_tb.sv */
`timescale 1ns/1ps
`include "msgbuf_defs.vh"
module msg_buffer_fields_tb;
	reg         pclk, presetn, slot_end, macrotick, slot_dynamic, rx_done, rx_channel;
	reg         rx_syntax_ok, rx_content_ok, rx_boundary, rx_data_valid, rx_busy;
	reg         fifo_accept, fifo_reject;
	reg  [10:0] slot_number, rx_frame_id, rx_crc, crc0, crc2, tx_crc_s;
	reg  [15:0] rx_header, rx_data, lfsr, tx_hdr;
	reg  [6:0]  rx_length, tx_len_s;
	reg  [3:0]  rx_data_index, tx_data_index;
	reg  [31:0] rdv;
	reg  [10:0] fq[$];
	integer     error_cnt, samples_checked, tx_cnt, tx_slot;
	wire        psel, penable, pwrite, pready, pslverr, tx_start, tx_channel_a, tx_channel_b;
	wire        fifo_write, status_update_done;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [15:0] tx_header, tx_data;
	wire [6:0]  tx_length;
	wire [10:0] tx_crc, fifo_frame_id;
	msg_buffer_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .slot_end, .macrotick, .slot_number, .slot_dynamic, .rx_done,
		.rx_channel, .rx_frame_id, .rx_header, .rx_length, .rx_crc, .rx_syntax_ok,
		.rx_content_ok, .rx_boundary, .rx_data_valid, .rx_data_index, .rx_data, .rx_busy,
		.fifo_accept, .fifo_reject, .tx_start, .tx_header, .tx_length, .tx_crc, .tx_channel_a,
		.tx_channel_b, .tx_data_index, .tx_data, .fifo_write, .fifo_frame_id, .status_update_done);
	apb_host_model host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	function [15:0] nxt(input [15:0] s);
		nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		host_u.xfer(1'b1, a, d, rdv);
	endtask
	task rd(input [11:0] a);
		host_u.xfer(1'b0, a, 32'h00000000, rdv);
	endtask
	// buffer memory reads carry one wait state
	task rdm(input [11:0] a);
		rd(a);
	endtask
	task run_slot(input [10:0] n, input rx);
		integer i;
		begin
			@(posedge pclk);
			slot_number <= n;
			macrotick <= 1'b0;
			for (i = 0; i < 12; i = i + 1) begin
				@(posedge pclk);
				macrotick <= (i % 4 == 3);
				slot_end <= (i == 7);
				rx_done <= rx && i >= 4 && i < 11;
				rx_data_valid <= rx && (i == 4 || i == 5);
				rx_data_index <= i - 4;
			end
			@(posedge pclk);
			macrotick <= 1'b0;
			slot_end <= 1'b0;
			rx_done <= 1'b0;
			rx_data_valid <= 1'b0;
		end
	endtask
	task tally_and_finish;
		begin
			$display("errors %0d checks %0d", error_cnt, samples_checked);
			if (error_cnt == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge pclk) begin
		if (tx_start === 1'b1) begin
			tx_cnt <= tx_cnt + 1;
			tx_slot <= slot_number;
			tx_hdr <= tx_header;
			tx_crc_s <= tx_crc;
			tx_len_s <= tx_length;
		end
		if (fifo_write === 1'b1) begin
			if (fq.size() == 0)
				chk("fifo_write", 0, 1);
			else
				chk("fifo_frame_id", fq.pop_front(), fifo_frame_id);
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt = error_cnt + 1;
		tally_and_finish;
	end
	initial begin
		{slot_end, macrotick, slot_dynamic, rx_done, rx_channel, rx_boundary} = 6'h00;
		{rx_data_valid, rx_busy, fifo_accept, fifo_reject} = 4'h0;
		{rx_syntax_ok, rx_content_ok} = 2'h3;
		{slot_number, rx_frame_id, rx_crc, rx_header, rx_data, rx_length} = 0;
		{rx_data_index, tx_data_index} = 8'h00;
		{error_cnt, samples_checked, tx_cnt, tx_slot} = 0;
		lfsr = 16'h0010;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`REG_SPL);
		chk("spl_reset", `SPL_RST, rdv);
		rd(`REG_MPL);
		chk("mpl_reset", `MPL_RST, rdv);
		rd(`REG_ERR);
		chk("err_reset", 0, rdv);
		rd(`REG_STATUS0);
		chk("status_reset", `STATUS_RST, rdv);
		rd(12'h018);
		chk("unmapped", 0, rdv);
		wr(`REG_STATUS0, 32'h0000FFFF);
		rd(`REG_STATUS0);
		chk("status_ro", 0, rdv[15:0]);
		wr(`REG_BUFCFG0, 32'h00009005);
		wr(`REG_BUFCFG0 + 12'h004, 32'h0000D006);
		wr(`REG_BUFCFG0 + 12'h008, 32'h00001009);
		wr(12'h404, 32'h00000003);
		rd(`REG_ERR);
		chk("static_len_err", 1, rdv[1:0]);
		wr(`REG_ERR, 32'h00000001);
		wr(12'h404, 32'h00000010);
		rd(`REG_ERR);
		chk("static_len_ok", 0, rdv[1:0]);
		wr(12'h444, 32'h00000011);
		rd(`REG_ERR);
		chk("dyn_len_err", 2, rdv[1:0]);
		wr(`REG_ERR, 32'h00000002);
		wr(12'h444, 32'h00000010);
		rd(`REG_ERR);
		chk("dyn_len_ok", 0, rdv[1:0]);
		lfsr = nxt(lfsr);
		crc0 = lfsr[10:0];
		wr(12'h400, 32'h00004005);
		wr(12'h408, {21'h0, crc0});
		wr(`REG_CTRL, 32'h00000001);
		run_slot(11'h004, 1'b0);
		rx_busy <= 1'b1;
		run_slot(11'h005, 1'b0);
		rx_busy <= 1'b0;
		run_slot(11'h007, 1'b0);
		chk("tx_count", 1, tx_cnt);
		chk("tx_slot", 5, tx_slot);
		chk("tx_hdr", 16'h4005 & 16'hC7FF, tx_hdr & 16'hC7FF);
		chk("tx_crc", crc0, tx_crc_s);
		chk("tx_len", 7'h10, tx_len_s);
		rd(`REG_STATUS0);
		chk("tx_status", 16'h0001, rdv[15:0]);
		lfsr = nxt(lfsr);
		crc2 = lfsr[10:0];
		lfsr = nxt(lfsr);
		rx_frame_id <= 11'h009;
		rx_header <= 16'h3009;
		rx_length <= 7'h02;
		rx_crc <= crc2;
		rx_data <= lfsr;
		run_slot(11'h009, 1'b1);
		rd(`REG_STATUS0 + 12'h008);
		chk("rx_status", 16'h00C0, rdv[15:0] & 16'h01DF);
		chk("rx_null_ind", 1, rdv[19]);
		rdm(12'h488);
		chk("rx_crc", crc2, rdv[10:0]);
		rdm(12'h484);
		chk("rx_len", 2, rdv[6:0]);
		rdm(12'h48C);
		chk("rx_data", lfsr, rdv[15:0]);
		rx_syntax_ok <= 1'b0;
		rx_crc <= ~crc2;
		run_slot(11'h009, 1'b1);
		rd(`REG_STATUS0 + 12'h008);
		chk("bad_status", 16'h0008, rdv[15:0] & 16'h01DF);
		rdm(12'h488);
		chk("bad_crc_kept", crc2, rdv[10:0]);
		rx_syntax_ok <= 1'b1;
		fifo_accept <= 1'b1;
		rx_frame_id <= 11'h033;
		rx_header <= 16'h2033;
		fq.push_back(11'h033);
		run_slot(11'h033, 1'b1);
		fifo_reject <= 1'b1;
		rx_frame_id <= 11'h034;
		run_slot(11'h034, 1'b1);
		fifo_reject <= 1'b0;
		rx_frame_id <= 11'h035;
		rx_header <= 16'h0035;
		run_slot(11'h035, 1'b1);
		chk("fifo_pending", 0, fq.size());
		tally_and_finish;
	end
endmodule
